// file: design/dsc_drive_status.sv
// Purpose: frequency arrival, current alarm and pid excess status outputs
// Assumes: measurement inputs come from logic on i_clk
// Notes:   one wait state on every bus access
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps

// Behaviour
// - arrival flags assert within 1% of max
// - arrival flags clear beyond 2% of max
// - setpoint arrival compares against setpoint frequency
// - over flag: on accel threshold, off decel
// - equal on and off thresholds work
// - pulse flag on at accel threshold while accelerating
// - pulse flag likewise around decel threshold
// - first current alarm follows first limit
// - second current alarm uses own limit
// - current alarms active driving and regenerating
// - terminal high only while condition present
// - first current limit resets to 100%
// - code 03 selects first current alarm
// - pid error is absolute setpoint difference
// - pid flag set above, cleared below limit
// - pid limit resets to three percent
// - code 04 selects pid excess flag
// - codes 01 02 06 select arrival flags
module dsc_drive_status
   import dsc_pkg::*;
#(
   parameter int NUM_TERM = 2
) (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // avalon-mm slave
   input  wire logic [DSC_AW-1:0]     i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [31:0]           i_avs_writedata,
   output logic      [31:0]           o_avs_readdata,
   output logic                       o_avs_waitrequest,
   // drive measurements
   input  wire logic [DSC_DW-1:0]     i_out_freq,
   input  wire logic [DSC_DW-1:0]     i_out_current,
   input  wire logic [DSC_DW-1:0]     i_pid_setpoint,
   input  wire logic [DSC_DW-1:0]     i_pid_process,
   // status flags
   output logic                       o_arrival_at_setpoint,
   output logic                       o_arrival_over_threshold,
   output logic                       o_arrival_at_threshold_pulse,
   output logic                       o_current_alarm_first,
   output logic                       o_current_alarm_second,
   output logic                       o_pid_error_excess_flag,
   // relay terminals
   output logic      [NUM_TERM-1:0]   o_term
);

   logic [15:0]          max_freq;
   logic [15:0]          setpoint_frequency;
   logic [15:0]          accel_on_threshold;
   logic [15:0]          decel_off_threshold;
   logic [15:0]          current_limit_first;
   logic [15:0]          current_limit_second;
   logic [15:0]          pid_error_limit;
   logic [7:0]           term_sel [NUM_TERM];
   logic [15:0]          freq_q;
   logic [15:0]          freq_prev;
   logic [15:0]          cur_q;
   logic [15:0]          pid_err;
   logic [15:0]          band_on;
   logic [15:0]          band_off;
   dsc_dir_t             dir;
   logic                 req;
   logic                 bus_ack;
   logic [7:0]           status;
   logic [15:0]          d_set;
   logic [15:0]          d_acc;
   logic [15:0]          d_dec;

   function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: request held until waitrequest is seen low
   assign req     = i_avs_read | i_avs_write;
   assign bus_ack = req & ~o_avs_waitrequest;

   always_ff @(posedge i_clk) begin
      o_avs_waitrequest <= i_rst || bus_ack || !req;
   end

   // unmapped addresses read as zero and ignore writes
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_avs_readdata <= 32'h0000_0000;
      end else if (i_avs_read && o_avs_waitrequest) begin
         unique case (i_avs_address)
            DSC_OFS_MAX_FREQ:   o_avs_readdata <= {16'h0000, max_freq};
            DSC_OFS_SETPOINT:   o_avs_readdata <= {16'h0000, setpoint_frequency};
            DSC_OFS_ACCEL_ON:   o_avs_readdata <= {16'h0000, accel_on_threshold};
            DSC_OFS_DECEL_OFF:  o_avs_readdata <= {16'h0000, decel_off_threshold};
            DSC_OFS_CUR_FIRST:  o_avs_readdata <= {16'h0000, current_limit_first};
            DSC_OFS_CUR_SECOND: o_avs_readdata <= {16'h0000, current_limit_second};
            DSC_OFS_PID_LIMIT:  o_avs_readdata <= {16'h0000, pid_error_limit};
            DSC_OFS_TERM_SEL:   o_avs_readdata <= {16'h0000, term_sel[1], term_sel[0]};
            DSC_OFS_STATUS:     o_avs_readdata <= {24'h00_0000, status};
            default:            o_avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         max_freq             <= DSC_RST_MAX_FREQ;
         setpoint_frequency   <= DSC_RST_SETPOINT;
         accel_on_threshold   <= DSC_RST_ACCEL_ON;
         decel_off_threshold  <= DSC_RST_DECEL_OFF;
         current_limit_first  <= DSC_RST_CUR_FIRST;
         current_limit_second <= DSC_RST_CUR_SECOND;
         pid_error_limit      <= DSC_RST_PID_LIMIT;
         term_sel[0]          <= DSC_RST_TERM0_SEL;
         term_sel[1]          <= DSC_RST_TERM1_SEL;
      end else if (i_avs_write && !o_avs_waitrequest) begin
         unique case (i_avs_address)
            DSC_OFS_MAX_FREQ:   max_freq             <= i_avs_writedata[15:0];
            DSC_OFS_SETPOINT:   setpoint_frequency   <= i_avs_writedata[15:0];
            DSC_OFS_ACCEL_ON:   accel_on_threshold   <= i_avs_writedata[15:0];
            DSC_OFS_DECEL_OFF:  decel_off_threshold  <= i_avs_writedata[15:0];
            DSC_OFS_CUR_FIRST:  current_limit_first  <= i_avs_writedata[15:0];
            DSC_OFS_CUR_SECOND: current_limit_second <= i_avs_writedata[15:0];
            DSC_OFS_PID_LIMIT:  pid_error_limit      <= i_avs_writedata[15:0];
            DSC_OFS_TERM_SEL: begin
               term_sel[0] <= i_avs_writedata[7:0];
               term_sel[1] <= i_avs_writedata[15:8];
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered samples and direction
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         freq_q    <= 16'h0000;
         freq_prev <= 16'h0000;
         cur_q     <= 16'h0000;
         pid_err   <= 16'h0000;
         dir       <= DSC_DIR_STEADY;
      end else begin
         freq_q    <= i_out_freq;
         freq_prev <= freq_q;
         cur_q     <= i_out_current;
         pid_err   <= abs_diff(i_pid_setpoint, i_pid_process);
         // a flat stretch keeps the last direction so pulses do not flicker
         if (freq_q > freq_prev) begin
            dir <= DSC_DIR_ACCEL;
         end else if (freq_q < freq_prev) begin
            dir <= DSC_DIR_DECEL;
         end
      end
   end

   // bands follow max_freq one cycle late after a write; no reset, they settle during it
   always_ff @(posedge i_clk) begin
      band_on  <= 16'((17'(max_freq) * DSC_HYST_ON_PCT) / DSC_PCT_DIV);
      band_off <= 16'((17'(max_freq) * DSC_HYST_OFF_PCT) / DSC_PCT_DIV);
   end

   assign d_set = abs_diff(freq_q, setpoint_frequency);
   assign d_acc = abs_diff(freq_q, accel_on_threshold);
   assign d_dec = abs_diff(freq_q, decel_off_threshold);

   ////////////////////////////////////////////////////////////////////////////
   // frequency arrival flags
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_arrival_at_setpoint <= 1'b0;
      end else if (d_set <= band_on) begin
         o_arrival_at_setpoint <= 1'b1;
      end else if (d_set > band_off) begin
         o_arrival_at_setpoint <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_arrival_over_threshold <= 1'b0;
      end else if (dir == DSC_DIR_ACCEL &&
                   17'(freq_q) + 17'(band_on) >= 17'(accel_on_threshold)) begin
         o_arrival_over_threshold <= 1'b1;
      end else if (dir == DSC_DIR_DECEL &&
                   17'(freq_q) + 17'(band_off) < 17'(decel_off_threshold)) begin
         o_arrival_over_threshold <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_arrival_at_threshold_pulse <= 1'b0;
      end else if ((dir == DSC_DIR_ACCEL && d_acc <= band_on) ||
                   (dir == DSC_DIR_DECEL && d_dec <= band_on)) begin
         o_arrival_at_threshold_pulse <= 1'b1;
      end else if (d_acc > band_off && d_dec > band_off) begin
         o_arrival_at_threshold_pulse <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // current and pid comparisons; equality holds the last state
   // no direction gating
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_current_alarm_first  <= 1'b0;
         o_current_alarm_second <= 1'b0;
         o_pid_error_excess_flag <= 1'b0;
      end else begin
         if (cur_q > current_limit_first)
            o_current_alarm_first <= 1'b1;
         else if (cur_q < current_limit_first)
            o_current_alarm_first <= 1'b0;
         if (cur_q > current_limit_second)
            o_current_alarm_second <= 1'b1;
         else if (cur_q < current_limit_second)
            o_current_alarm_second <= 1'b0;
         if (pid_err > pid_error_limit)
            o_pid_error_excess_flag <= 1'b1;
         else if (pid_err < pid_error_limit)
            o_pid_error_excess_flag <= 1'b0;
      end
   end

   always_comb begin
      status[DSC_ST_AT_SETPOINT] = o_arrival_at_setpoint;
      status[DSC_ST_OVER_THR]    = o_arrival_over_threshold;
      status[DSC_ST_THR_PULSE]   = o_arrival_at_threshold_pulse;
      status[DSC_ST_CUR_FIRST]   = o_current_alarm_first;
      status[DSC_ST_CUR_SECOND]  = o_current_alarm_second;
      status[DSC_ST_PID_EXCESS]  = o_pid_error_excess_flag;
      status[DSC_ST_ACCEL]       = (dir == DSC_DIR_ACCEL);
      status[DSC_ST_DECEL]       = (dir == DSC_DIR_DECEL);
   end

   ////////////////////////////////////////////////////////////////////////////
   // terminal routing; unknown codes leave the contact open
   for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            o_term[t] <= 1'b0;
         end else begin
            unique case (term_sel[t])
               DSC_FN_AT_SETPOINT: o_term[t] <= o_arrival_at_setpoint;
               DSC_FN_OVER_THR:    o_term[t] <= o_arrival_over_threshold;
               DSC_FN_CUR_FIRST:   o_term[t] <= o_current_alarm_first;
               DSC_FN_PID_EXCESS:  o_term[t] <= o_pid_error_excess_flag;
               DSC_FN_THR_PULSE:   o_term[t] <= o_arrival_at_threshold_pulse;
               default:            o_term[t] <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_cur_high;
      cur_q > current_limit_first && $stable(current_limit_first);
   endsequence
   sequence s_cur_low;
      cur_q < current_limit_first && $stable(current_limit_first);
   endsequence
   property p_fa_on;
      (d_set <= band_on) |=> o_arrival_at_setpoint;
   endproperty
   a_fa_on: assert property (p_fa_on) else $error("setpoint arrival late");
   property p_fa_hold;
      (o_arrival_at_setpoint && d_set <= band_off) |=> o_arrival_at_setpoint;
   endproperty
   a_fa_hold: assert property (p_fa_hold) else $error("setpoint arrival chatter");
   property p_fa_off;
      (d_set > band_off) |=> !o_arrival_at_setpoint;
   endproperty
   a_fa_off: assert property (p_fa_off) else $error("setpoint arrival stuck");
   property p_over_hold;
      (o_arrival_over_threshold && dir != DSC_DIR_DECEL) |=> o_arrival_over_threshold;
   endproperty
   a_over_hold: assert property (p_over_hold) else $error("over flag cleared on accel");
   property p_over_eq;
      (accel_on_threshold == decel_off_threshold && dir == DSC_DIR_ACCEL
       && freq_q >= accel_on_threshold) |=> o_arrival_over_threshold;
   endproperty
   a_over_eq: assert property (p_over_eq) else $error("over flag equal limits");
   property p_pulse_off;
      (d_acc > band_off && d_dec > band_off) |=> !o_arrival_at_threshold_pulse;
   endproperty
   a_pulse_off: assert property (p_pulse_off) else $error("pulse flag stuck");
   property p_pulse_dec;
      (dir == DSC_DIR_DECEL && d_dec <= band_on) |=> o_arrival_at_threshold_pulse;
   endproperty
   a_pulse_dec: assert property (p_pulse_dec) else $error("decel pulse missing");
   property p_cur_first;
      (s_cur_high |=> o_current_alarm_first) and (s_cur_low |=> !o_current_alarm_first);
   endproperty
   a_cur_first: assert property (p_cur_first) else $error("first alarm wrong");
   property p_cur_second;
      (cur_q > current_limit_second) |=> o_current_alarm_second;
   endproperty
   a_cur_second: assert property (p_cur_second) else $error("second alarm wrong");
   property p_pid;
      (pid_err < pid_error_limit) |=> !o_pid_error_excess_flag;
   endproperty
   a_pid: assert property (p_pid) else $error("pid flag not cleared");
   property p_term_ol;
      (term_sel[0] == DSC_FN_CUR_FIRST && $stable(term_sel[0]))
         |=> o_term[0] == $past(o_current_alarm_first);
   endproperty
   a_term_ol: assert property (p_term_ol) else $error("terminal routing wrong");
   property p_bus;
      (req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
   endproperty
   a_bus: assert property (p_bus) else $error("bus handshake wrong");

endmodule

// file: design/dsc_pkg.sv
// Purpose: constants shared by the drive status comparator block
// Assumes: frequency in 0.01 Hz steps, current and pid values in 0.1 % steps
// Notes:   register map is word aligned on an avalon-mm slave
package dsc_pkg;

   localparam int DSC_DW = 16;
   localparam int DSC_AW = 6;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [5:0] DSC_OFS_MAX_FREQ   = 6'h00;
   localparam logic [5:0] DSC_OFS_SETPOINT   = 6'h04;
   localparam logic [5:0] DSC_OFS_ACCEL_ON   = 6'h08;
   localparam logic [5:0] DSC_OFS_DECEL_OFF  = 6'h0c;
   localparam logic [5:0] DSC_OFS_CUR_FIRST  = 6'h10;
   localparam logic [5:0] DSC_OFS_CUR_SECOND = 6'h14;
   localparam logic [5:0] DSC_OFS_PID_LIMIT  = 6'h18;
   localparam logic [5:0] DSC_OFS_TERM_SEL   = 6'h1c;
   localparam logic [5:0] DSC_OFS_STATUS     = 6'h20;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] DSC_RST_MAX_FREQ   = 16'h1770;
   localparam logic [15:0] DSC_RST_SETPOINT   = 16'h0000;
   localparam logic [15:0] DSC_RST_ACCEL_ON   = 16'h0000;
   localparam logic [15:0] DSC_RST_DECEL_OFF  = 16'h0000;
   localparam logic [15:0] DSC_RST_CUR_FIRST  = 16'h03e8;
   localparam logic [15:0] DSC_RST_CUR_SECOND = 16'h03e8;
   localparam logic [15:0] DSC_RST_PID_LIMIT  = 16'h001e;
   localparam logic [7:0]  DSC_RST_TERM0_SEL  = 8'h01;
   localparam logic [7:0]  DSC_RST_TERM1_SEL  = 8'h03;

   ////////////////////////////////////////////////////////////////////////////
   // hysteresis as fractions of the maximum frequency, in percent
   localparam logic [16:0] DSC_PCT_DIV    = 17'h00064;
   localparam logic [16:0] DSC_HYST_ON_PCT  = 17'h00001;
   localparam logic [16:0] DSC_HYST_OFF_PCT = 17'h00002;

   ////////////////////////////////////////////////////////////////////////////
   // terminal function codes
   localparam logic [7:0] DSC_FN_AT_SETPOINT = 8'h01;
   localparam logic [7:0] DSC_FN_OVER_THR    = 8'h02;
   localparam logic [7:0] DSC_FN_CUR_FIRST   = 8'h03;
   localparam logic [7:0] DSC_FN_PID_EXCESS  = 8'h04;
   localparam logic [7:0] DSC_FN_THR_PULSE   = 8'h06;

   ////////////////////////////////////////////////////////////////////////////
   // status bit positions
   localparam int DSC_ST_AT_SETPOINT = 0;
   localparam int DSC_ST_OVER_THR    = 1;
   localparam int DSC_ST_THR_PULSE   = 2;
   localparam int DSC_ST_CUR_FIRST   = 3;
   localparam int DSC_ST_CUR_SECOND  = 4;
   localparam int DSC_ST_PID_EXCESS  = 5;
   localparam int DSC_ST_ACCEL       = 6;
   localparam int DSC_ST_DECEL       = 7;

   typedef enum logic [1:0] {
      DSC_DIR_STEADY = 2'b00,
      DSC_DIR_ACCEL  = 2'b01,
      DSC_DIR_DECEL  = 2'b10
   } dsc_dir_t;

endpackage

// file: tb/dsc_relay_reader.sv
// Purpose: control equipment that reads the relay terminals
// Assumes: terminal high means contact closed
// Notes:   one register stage, like an input filter of a controller
`timescale 1ns/1ps
module dsc_relay_reader #(
   parameter int NUM_TERM = 2
) (
   // clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // relay terminals
   input  wire logic [NUM_TERM-1:0] i_term,
   // contact view
   output logic      [NUM_TERM-1:0] o_closed
);
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_closed <= '0;
      end else begin
         o_closed <= i_term;
      end
   end
endmodule

// file: tb/drive_status_comparators_test.sv
// Purpose: self-checking bench for the drive status comparators
// Assumes: one wait state per bus access, flags two edges behind inputs, over and pulse flags three on a change of direction
// Notes:   bus waits are open ended; only the watchdog ends a hang
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
   $display("FAIL %0t got %h exp %h", $time, (a), (b)); end end
module drive_status_comparators_test;
   import dsc_pkg::*;
   logic              i_clk = 1'b0;
   logic              i_rst = 1'b1;
   logic [DSC_AW-1:0] i_avs_address = '0;
   logic              i_avs_read = 1'b0;
   logic              i_avs_write = 1'b0;
   logic [31:0]       i_avs_writedata = '0;
   logic [31:0]       o_avs_readdata;
   logic              o_avs_waitrequest;
   logic [15:0]       meas [4] = '{default: 16'h0000};
   logic              f_set, f_over, f_pulse, f_cur1, f_cur2, f_pid;
   logic [1:0]        o_term, closed;
   logic [31:0]       rd;
   int                n_errors = 0;
   int                checks_done = 0;
   localparam logic [15:0] RV [8] = '{16'h1770, 16'h0000, 16'h0000, 16'h0000,
                                      16'h03e8, 16'h03e8, 16'h001e, 16'h0301};
   localparam logic [15:0] FR [11] = '{16'd1000, 16'd3939, 16'd3940, 16'd4121,
      16'd3060, 16'd2880, 16'd2879, 16'd3440, 16'd3500, 16'd3380, 16'd3379};
   localparam logic [1:0] EX [11] = '{2'b00, 2'b00, 2'b11, 2'b10, 2'b11, 2'b11,
                                      2'b00, 2'b11, 2'b11, 2'b11, 2'b00};
   localparam logic [7:0] CD [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h05};

   dsc_drive_status #(.NUM_TERM(2)) dsc_drive_status_i (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_out_freq(meas[0]), .i_out_current(meas[1]),
      .i_pid_setpoint(meas[2]), .i_pid_process(meas[3]),
      .o_arrival_at_setpoint(f_set), .o_arrival_over_threshold(f_over),
      .o_arrival_at_threshold_pulse(f_pulse), .o_current_alarm_first(f_cur1),
      .o_current_alarm_second(f_cur2), .o_pid_error_excess_flag(f_pid),
      .o_term(o_term));
   dsc_relay_reader #(.NUM_TERM(2)) dsc_relay_reader_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_term(o_term), .o_closed(closed));

   initial begin
      forever #25 i_clk = ~i_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // request stands until waitrequest is sampled low at a rising edge; data taken there
   task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_avs_address   <= a;
      i_avs_writedata <= {16'h0000, d};
      i_avs_write     <= wr;
      i_avs_read      <= ~wr;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0) begin
         @(posedge i_clk);
      end
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read  <= 1'b0;
   endtask

   task automatic step(input int w, input logic [15:0] v);
      @(posedge i_clk);
      meas[w] <= v;
      repeat (5) @(posedge i_clk);
      @(negedge i_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         bus(1'b0, 6'(4 * k), 16'h0000);
         `CHK(rd, {16'h0000, RV[k]})
      end
      bus(1'b1, 6'h24, 16'h1234);
      bus(1'b0, 6'h24, 16'h0000);
      `CHK(rd, 32'h00000000)
      // zero frequency sits on the zero default setpoint, so setpoint arrival is up
      bus(1'b0, DSC_OFS_STATUS, 16'h0000);
      `CHK(rd, 32'h00000001)
      // setpoint arrival band edges with max 60.00 Hz
      bus(1'b1, DSC_OFS_SETPOINT, 16'd3000);
      step(0, 16'd2939);
      `CHK(f_set, 1'b0)
      step(0, 16'd2940);
      `CHK(f_set, 1'b1)
      step(0, 16'd3120);
      `CHK(f_set, 1'b1)
      step(0, 16'd3121);
      `CHK(f_set, 1'b0)
      // over and pulse flags, then equal thresholds
      bus(1'b1, DSC_OFS_ACCEL_ON, 16'd4000);
      bus(1'b1, DSC_OFS_DECEL_OFF, 16'd3000);
      for (int k = 0; k < 11; k++) begin
         if (k == 7) begin
            bus(1'b1, DSC_OFS_ACCEL_ON, 16'd3500);
            bus(1'b1, DSC_OFS_DECEL_OFF, 16'd3500);
         end
         step(0, FR[k]);
         `CHK({f_over, f_pulse}, EX[k])
      end
      // current alarms, own limits, checked while decelerating only
      bus(1'b1, DSC_OFS_CUR_SECOND, 16'd500);
      step(1, 16'd1001);
      `CHK({f_cur1, f_cur2}, 2'b11)
      step(0, 16'd1000);
      `CHK({f_cur1, f_cur2}, 2'b11)
      step(1, 16'd1000);
      `CHK(f_cur1, 1'b1)
      step(1, 16'd999);
      `CHK({f_cur1, f_cur2}, 2'b01)
      step(1, 16'd499);
      `CHK(f_cur2, 1'b0)
      bus(1'b1, DSC_OFS_CUR_FIRST, 16'h0200);
      step(1, 16'h0300);
      `CHK({f_cur1, f_cur2}, 2'b11)
      // pid error magnitude both signs
      step(2, 16'd500);
      step(3, 16'd531);
      `CHK(f_pid, 1'b1)
      step(3, 16'd471);
      `CHK(f_pid, 1'b0)
      step(3, 16'd469);
      `CHK(f_pid, 1'b1)
      step(3, 16'd470);
      `CHK(f_pid, 1'b1)
      step(3, 16'd529);
      `CHK(f_pid, 1'b0)
      bus(1'b1, DSC_OFS_PID_LIMIT, 16'd10);
      step(3, 16'd511);
      `CHK(f_pid, 1'b1)
      // all flags up, then each terminal code
      bus(1'b1, DSC_OFS_ACCEL_ON, 16'd4000);
      bus(1'b1, DSC_OFS_DECEL_OFF, 16'd3000);
      bus(1'b1, DSC_OFS_SETPOINT, 16'd3940);
      step(0, 16'd3940);
      bus(1'b0, DSC_OFS_STATUS, 16'h0000);
      `CHK(rd, 32'h0000007f)
      for (int k = 0; k < 6; k++) begin
         bus(1'b1, DSC_OFS_TERM_SEL, {8'h00, CD[k]});
         step(0, 16'd3940);
         `CHK(closed, {1'b0, k < 5})
      end
      // flags now differ: setpoint and pulse drop, over, current and pid stay up
      bus(1'b1, DSC_OFS_TERM_SEL, 16'h0602);
      step(0, 16'd4121);
      `CHK(closed, 2'b01)
      bus(1'b1, DSC_OFS_TERM_SEL, 16'h0104);
      step(0, 16'd4121);
      `CHK(closed, 2'b01)
      bus(1'b1, DSC_OFS_TERM_SEL, 16'h0003);
      step(1, 16'h0100);
      `CHK(closed, 2'b00)
      step(1, 16'h0201);
      `CHK(closed, 2'b01)
      wrap_up();
   end
endmodule
